// [hdl/supply_temp_monitor_alert.sv]
// monitoring sequencer, limit checks, fault flags and alert pin
`timescale 1ns/1ps
module supply_temp_monitor_alert #(
   parameter int unsigned TEMP_CYC = supply_temp_monitor_pkg::TEMP_CONV_CYC,
   parameter int unsigned VOLT_CYC = supply_temp_monitor_pkg::VOLT_CONV_CYC
) (
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire logic                                power_good,
   input  wire supply_temp_monitor_pkg::reg_req_type reg_req,
   output logic [7:0]                               reg_rdata_ff,
   input  wire logic [7:0]                          adc_code,
   output logic [2:0]                               adc_slot_ff,
   output logic                                     conv_active_ff,
   output logic                                     alert_out_ff,
   output logic                                     alert_oe_n_ff
);
   import supply_temp_monitor_pkg::*;

   localparam logic [31:0] T_LEN    = TEMP_CYC;
   localparam logic [31:0] V_LEN    = VOLT_CYC;
   localparam logic [31:0] T_LEN_50 =
      32'(longint'(TEMP_CYC) * FAST_OSC_HZ / SLOW_OSC_HZ);
   localparam logic [31:0] V_LEN_50 =
      32'(longint'(VOLT_CYC) * FAST_OSC_HZ / SLOW_OSC_HZ);

   logic          pg_s1_ff;
   logic          pg_s2_ff;
   logic          pg_s3_ff;
   logic          por_ok_ff;
   seq_state_type state_ff;
   logic [31:0]   cnt_ff;
   ctrl_type      ctrl_ff;
   logic [7:0]    hot_ff;
   logic [7:0]    rel_ff;
   logic [7:0]    mask_ff;
   logic [7:0]    tcfg_ff;
   logic [7:0]    vhi_ff [NUM_VOLT];
   logic [7:0]    vlo_ff [NUM_VOLT];
   logic [7:0]    data_ff [STAT_W];
   logic [STAT_W-1:0] stat_ff;
   logic [STAT_W-1:0] nxt_stat;
   logic [STAT_W-1:0] set_vec;
   logic          temp_hot_ff;
   logic          wr;
   logic          rd;
   logic          soft_rst;
   logic          hold;
   logic          run;
   logic          slot_end;
   logic          temp_end;
   logic          stat_rd;
   logic          cmp_mode;
   logic          t_over;
   logic          t_under;
   logic [1:0]    vidx;
   logic [7:0]    rd_val;
   tmode_type     tmode;

   // conversion length of one slot from the timing bits
   function automatic logic [31:0] slot_len(input logic [2:0] slot,
                                            input ctrl_type c);
      logic [31:0] len;
      if (slot == SLOT_TEMP) begin
         len = c.line50 ? T_LEN_50 : T_LEN;
      end else begin
         len = c.line50 ? V_LEN_50 : V_LEN;
      end
      if (c.short_cyc) begin
         len = len >> SHORT_SHIFT;
      end
      if (len == 32'h0) begin
         len = 32'h1;
      end
      return len - 32'h1;
   endfunction

   // power-good pin synchroniser, change taken once stages agree
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pg_s1_ff  <= 1'b0;
         pg_s2_ff  <= 1'b0;
         pg_s3_ff  <= 1'b0;
         por_ok_ff <= 1'b0;
      end else begin
         pg_s1_ff <= power_good;
         pg_s2_ff <= pg_s1_ff;
         pg_s3_ff <= pg_s2_ff;
         if (pg_s2_ff == pg_s3_ff) begin
            por_ok_ff <= pg_s3_ff;
         end
      end
   end

   // register port accepted only with supply good
   assign wr       = reg_req.wr & por_ok_ff;
   assign rd       = reg_req.rd & por_ok_ff;
   assign soft_rst = wr & reg_req.wdata[7] &
                     ((reg_req.addr == ADDR_CTRL) ||
                      (reg_req.addr == ADDR_CTRL_ALT));
   assign hold     = soft_rst | ~por_ok_ff;
   assign run      = ctrl_ff.start & ~ctrl_ff.alert_clr;
   assign slot_end = (state_ff == ST_CONV) && (cnt_ff == 32'h0);
   assign temp_end = slot_end && (adc_slot_ff == SLOT_TEMP);
   assign stat_rd  = rd && (reg_req.addr == ADDR_STAT);
   assign tmode    = tmode_type'(tcfg_ff[1:0]);
   assign cmp_mode = (tmode == TM_CMP);
   assign t_over   = $signed(adc_code) > $signed(hot_ff);
   assign t_under  = $signed(adc_code) < $signed(rel_ff);
   assign vidx     = 2'(adc_slot_ff - 3'h1);

   // sequencer, alert does not stall it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff       <= ST_IDLE;
         cnt_ff         <= 32'h0;
         adc_slot_ff    <= SLOT_TEMP;
         conv_active_ff <= 1'b0;
      end else if (hold) begin
         state_ff       <= ST_IDLE;
         cnt_ff         <= 32'h0;
         adc_slot_ff    <= SLOT_TEMP;
         conv_active_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (run) begin
                  state_ff       <= ST_CONV;
                  adc_slot_ff    <= SLOT_TEMP;
                  cnt_ff         <= slot_len(SLOT_TEMP, ctrl_ff);
                  conv_active_ff <= 1'b1;
               end
            end
            ST_CONV: begin
               if (cnt_ff != 32'h0) begin
                  cnt_ff <= cnt_ff - 32'h1;
               end else if (adc_slot_ff == SLOT_LAST) begin
                  if (run) begin
                     adc_slot_ff <= SLOT_TEMP;
                     cnt_ff      <= slot_len(SLOT_TEMP, ctrl_ff);
                  end else begin
                     state_ff       <= ST_IDLE;
                     adc_slot_ff    <= SLOT_TEMP;
                     conv_active_ff <= 1'b0;
                  end
               end else begin
                  adc_slot_ff <= adc_slot_ff + 3'h1;
                  cnt_ff      <= slot_len(adc_slot_ff + 3'h1, ctrl_ff);
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // results stored at each slot end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < STAT_W; i++) begin
            data_ff[i] <= RST_BYTE;
         end
      end else if (hold) begin
         for (int i = 0; i < STAT_W; i++) begin
            data_ff[i] <= RST_BYTE;
         end
      end else if (temp_end) begin
         data_ff[TEMP_BIT] <= adc_code;
      end else if (slot_end) begin
         data_ff[vidx] <= adc_code;
      end
   end

   // temperature trip state between hot and release limits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         temp_hot_ff <= 1'b0;
      end else if (hold) begin
         temp_hot_ff <= 1'b0;
      end else if (temp_end) begin
         if (t_over) begin
            temp_hot_ff <= 1'b1;
         end else if (t_under) begin
            temp_hot_ff <= 1'b0;
         end
      end
   end

   // fault detection for the slot just finished
   always_comb begin
      set_vec = '0;
      if (temp_end) begin
         case (tmode)
            TM_ONCE: set_vec[TEMP_BIT] = (t_over & ~temp_hot_ff) |
                                         (t_under & temp_hot_ff);
            TM_CMP:  set_vec[TEMP_BIT] = t_over;
            default: set_vec[TEMP_BIT] = t_over |
                                         (temp_hot_ff & ~t_under);
         endcase
      end else if (slot_end) begin
         set_vec[vidx] = (adc_code > vhi_ff[vidx]) |
                         (adc_code < vlo_ff[vidx]);
      end
      set_vec = set_vec & ~mask_ff[STAT_W-1:0];
   end

   // status flags: read clears, set wins
   always_comb begin
      nxt_stat = stat_ff;
      if (stat_rd) begin
         nxt_stat = '0;
         nxt_stat[TEMP_BIT] = cmp_mode & stat_ff[TEMP_BIT];
      end
      if (temp_end && cmp_mode) begin
         nxt_stat[TEMP_BIT] = 1'b0;
      end
      nxt_stat = nxt_stat | set_vec;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_ff <= '0;
      end else if (hold) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   // host writable registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= ctrl_type'(RST_BYTE);
         hot_ff  <= RST_HOT;
         rel_ff  <= RST_REL;
         mask_ff <= RST_BYTE;
         tcfg_ff <= RST_BYTE;
      end else if (hold) begin
         ctrl_ff <= ctrl_type'(RST_BYTE);
         hot_ff  <= RST_HOT;
         rel_ff  <= RST_REL;
         mask_ff <= RST_BYTE;
         tcfg_ff <= RST_BYTE;
      end else if (wr) begin
         if ((reg_req.addr == ADDR_CTRL) ||
             (reg_req.addr == ADDR_CTRL_ALT)) begin
            ctrl_ff <= ctrl_type'(reg_req.wdata & CTRL_WR_MASK);
         end else if (reg_req.addr == ADDR_HOT) begin
            hot_ff <= reg_req.wdata;
         end else if (reg_req.addr == ADDR_REL) begin
            rel_ff <= reg_req.wdata;
         end else if (reg_req.addr == ADDR_MASK) begin
            mask_ff <= reg_req.wdata & MASK_WR_MASK;
         end else if (reg_req.addr == ADDR_TCFG) begin
            tcfg_ff <= reg_req.wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_VOLT; i++) begin
            vhi_ff[i] <= RST_VHI;
            vlo_ff[i] <= RST_VLO;
         end
      end else if (hold) begin
         for (int i = 0; i < NUM_VOLT; i++) begin
            vhi_ff[i] <= RST_VHI;
            vlo_ff[i] <= RST_VLO;
         end
      end else if (wr) begin
         for (int i = 0; i < NUM_VOLT; i++) begin
            if (reg_req.addr == ADDR_VHI0 + 8'(2 * i)) begin
               vhi_ff[i] <= reg_req.wdata;
            end else if (reg_req.addr == ADDR_VLO0 + 8'(2 * i)) begin
               vlo_ff[i] <= reg_req.wdata;
            end
         end
      end
   end

   // read data mux
   always_comb begin
      rd_val = RST_BYTE;
      for (int i = 0; i < NUM_VOLT; i++) begin
         if (reg_req.addr == ADDR_VDATA0 + 8'(i)) begin
            rd_val = data_ff[i];
         end else if (reg_req.addr == ADDR_VHI0 + 8'(2 * i)) begin
            rd_val = vhi_ff[i];
         end else if (reg_req.addr == ADDR_VLO0 + 8'(2 * i)) begin
            rd_val = vlo_ff[i];
         end
      end
      if (reg_req.addr == ADDR_TDATA) begin
         rd_val = data_ff[TEMP_BIT];
      end else if (reg_req.addr == ADDR_HOT) begin
         rd_val = hot_ff;
      end else if (reg_req.addr == ADDR_REL) begin
         rd_val = rel_ff;
      end else if (reg_req.addr == ADDR_CTRL_ALT) begin
         rd_val = ctrl_ff;
      end else if (reg_req.addr == ADDR_STAT) begin
         rd_val = 8'(stat_ff);
      end else if (reg_req.addr == ADDR_MASK) begin
         rd_val = mask_ff;
      end else if (reg_req.addr == ADDR_TCFG) begin
         rd_val = tcfg_ff;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata_ff <= RST_BYTE;
      end else if (rd) begin
         reg_rdata_ff <= rd_val;
      end
   end

   // open-drain alert, enable low while pulling low
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alert_out_ff  <= 1'b0;
         alert_oe_n_ff <= 1'b1;
      end else begin
         alert_out_ff  <= 1'b0;
         alert_oe_n_ff <= ~(ctrl_ff.alert_en & ~ctrl_ff.alert_clr &
                            |(stat_ff & ~mask_ff[STAT_W-1:0]));
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_start_temp;
      state_ff == ST_IDLE && run && !hold |=>
         conv_active_ff && adc_slot_ff == SLOT_TEMP;
   endproperty
   a_start_temp: assert property (p_start_temp)
      else $error("loop did not start at temperature");

   property p_order;
      slot_end && adc_slot_ff != SLOT_LAST && !hold |=>
         adc_slot_ff == 3'($past(adc_slot_ff) + 3'h1);
   endproperty
   a_order: assert property (p_order)
      else $error("conversion order broken");

   property p_finish;
      state_ff == ST_CONV && !run && !hold && !slot_end |=>
         state_ff == ST_CONV;
   endproperty
   a_finish: assert property (p_finish)
      else $error("cycle abandoned on stop");

   property p_alert_gate;
      !ctrl_ff.alert_en || ctrl_ff.alert_clr |=> alert_oe_n_ff;
   endproperty
   a_alert_gate: assert property (p_alert_gate)
      else $error("alert driven while disabled");

   property p_clr_halts;
      ctrl_ff.alert_clr && state_ff == ST_IDLE |=> !conv_active_ff;
   endproperty
   a_clr_halts: assert property (p_clr_halts)
      else $error("loop ran with clear bit set");

   property p_read_clear;
      stat_rd && !cmp_mode && set_vec == '0 && !hold |=> stat_ff == '0;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("status not cleared by read");

   property p_cmp_keep;
      stat_rd && cmp_mode && stat_ff[TEMP_BIT] && !temp_end && !hold
         |=> stat_ff[TEMP_BIT];
   endproperty
   a_cmp_keep: assert property (p_cmp_keep)
      else $error("comparator flag lost on read");

   property p_set_wins;
      set_vec != '0 && !hold |=> (stat_ff & $past(set_vec)) == $past(set_vec);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("fault lost");

   property p_soft_rst;
      soft_rst |=> ctrl_ff == ctrl_type'(RST_BYTE) && hot_ff == RST_HOT
         && stat_ff == '0 && !conv_active_ff;
   endproperty
   a_soft_rst: assert property (p_soft_rst)
      else $error("soft reset incomplete");

   property p_por_hold;
      !por_ok_ff |=> !conv_active_ff && stat_ff == '0;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("active while supply low");

   c_full_cycle: cover property (slot_end && adc_slot_ff == SLOT_LAST);
   c_alert:      cover property (!alert_oe_n_ff);
   c_cmp_read:   cover property (stat_rd && cmp_mode && stat_ff[TEMP_BIT]);
   c_soft_rst:   cover property (soft_rst);
endmodule

// [hdl/supply_temp_monitor_pkg.sv]
// constants and types for the supply and temperature monitor
// What this block does
// - control bit 0 set starts monitoring loop
// - order: temperature, 2.5V, 12V, 3.3V, supply
// - stop mid-cycle finishes and stores the cycle
// - restart always begins with temperature
// - limit crossing sets status bit, drives alert
// - status bits 0-3 voltages, 4 temperature
// - status read clears status and alert
// - comparator temperature bit survives status read
// - persisting fault re-alerts after next cycle
// - mask bit suppresses status and alert
// - control bit 1 enables alert output
// - control bit 0 clear stops, registers live
// - control bit 3 silences alert, halts loop
// - control bit 4 selects slower 51.2kHz timing
// - temperature 66ms, voltage 33ms per conversion
// - control bit 5 shortens conversions fourfold
// - control bit 7 restores all register defaults
// - hot limit 0x50, release limit 0x41
// - voltage limits 1.1 and 0.9 nominal
// - below power threshold: reset, shutdown, deaf
// - three temperature alert modes, voltages unaffected
// - mode 00/11 default, 01 once, 10 comparator
// - one-time mode re-alerts below release limit
// - comparator alert holds until below hot
// - alert never pauses conversions or results
package supply_temp_monitor_pkg;
   localparam logic [7:0] ADDR_VDATA0   = 8'h20;
   localparam logic [7:0] ADDR_TDATA    = 8'h27;
   localparam logic [7:0] ADDR_VHI0     = 8'h2B;
   localparam logic [7:0] ADDR_VLO0     = 8'h2C;
   localparam logic [7:0] ADDR_HOT      = 8'h39;
   localparam logic [7:0] ADDR_REL      = 8'h3A;
   localparam logic [7:0] ADDR_CTRL_ALT = 8'h40;
   localparam logic [7:0] ADDR_CTRL     = 8'h41;
   localparam logic [7:0] ADDR_STAT     = 8'h41;
   localparam logic [7:0] ADDR_MASK     = 8'h43;
   localparam logic [7:0] ADDR_TCFG     = 8'h4B;
   localparam logic [7:0] RST_VHI       = 8'hD3;
   localparam logic [7:0] RST_VLO       = 8'hAD;
   localparam logic [7:0] RST_HOT       = 8'h50;
   localparam logic [7:0] RST_REL       = 8'h41;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK  = 8'h3B;
   localparam logic [7:0] MASK_WR_MASK  = 8'h1F;
   localparam int          NUM_VOLT      = 4;
   localparam int          STAT_W        = 5;
   localparam int          TEMP_BIT      = 4;
   localparam logic [2:0]  SLOT_TEMP     = 3'h0;
   localparam logic [2:0]  SLOT_LAST     = 3'h4;
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned CYC_PER_MS    = CLK_MHZ * 1000;
   localparam int unsigned TEMP_CONV_MS  = 66;
   localparam int unsigned VOLT_CONV_MS  = 33;
   localparam int unsigned TEMP_CONV_CYC = TEMP_CONV_MS * CYC_PER_MS;
   localparam int unsigned VOLT_CONV_CYC = VOLT_CONV_MS * CYC_PER_MS;
   localparam longint unsigned FAST_OSC_HZ = 61400;
   localparam longint unsigned SLOW_OSC_HZ = 51200;
   localparam int          SHORT_SHIFT   = 2;

   typedef enum logic [1:0] {
      TM_DEF0 = 2'b00,
      TM_ONCE = 2'b01,
      TM_CMP  = 2'b10,
      TM_DEF3 = 2'b11
   } tmode_type;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } seq_state_type;

   typedef struct packed {
      logic soft_rst;
      logic rsvd6;
      logic short_cyc;
      logic line50;
      logic alert_clr;
      logic rsvd2;
      logic alert_en;
      logic start;
   } ctrl_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
endpackage

// [bench/adc_model.sv]
// converter stand-in that returns one code per monitored input
`timescale 1ns/1ps
module adc_model (
   input  wire logic            clk,
   input  wire logic [2:0]      adc_slot_ff,
   input  wire logic            conv_active_ff,
   input  wire logic [4:0][7:0] codes,
   output logic [7:0]           adc_code
);
   logic [7:0] last_ff;

   always_ff @(posedge clk) begin
      if (conv_active_ff) begin
         last_ff <= adc_code;
      end
   end

   // idle output flips away from the last code
   assign adc_code = conv_active_ff ? codes[adc_slot_ff] : ~last_ff;
endmodule

// [bench/tb.sv]
// register-level testbench of the monitor sequencer and alert
`timescale 1ns/1ps
module tb;
   import supply_temp_monitor_pkg::*;
   logic            clk;
   logic            sys_rst;
   logic            power_good;
   reg_req_type     reg_req;
   logic [7:0]      reg_rdata_ff;
   logic [7:0]      adc_code;
   logic [7:0]      v;
   logic [2:0]      adc_slot_ff;
   logic            conv_active_ff;
   logic            alert_out_ff;
   logic            alert_oe_n_ff;
   logic [4:0][7:0] codes;
   int              err_count;
   int              cmp_count;
   int              n;
   int              i;

   supply_temp_monitor_alert #(.TEMP_CYC(40), .VOLT_CYC(20))
      supply_temp_monitor_alert_inst (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .power_good     (power_good),
      .reg_req        (reg_req),
      .reg_rdata_ff   (reg_rdata_ff),
      .adc_code       (adc_code),
      .adc_slot_ff    (adc_slot_ff),
      .conv_active_ff (conv_active_ff),
      .alert_out_ff   (alert_out_ff),
      .alert_oe_n_ff  (alert_oe_n_ff)
   );

   adc_model adc_model_inst (
      .clk            (clk),
      .adc_slot_ff    (adc_slot_ff),
      .conv_active_ff (conv_active_ff),
      .codes          (codes),
      .adc_code       (adc_code)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wrap_up;
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         err_count++;
         $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      reg_req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      reg_req.rd = 1'b0;
      @(negedge clk);
      d = reg_rdata_ff;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk8(d, exp);
   endtask

   task automatic bad_wait;
      err_count++;
      $display("ERROR %0t: wait timed out", $time);
   endtask

   task automatic wait_slot(input logic [2:0] s);
      int k;
      k = 0;
      while (!(conv_active_ff === 1'b1 && adc_slot_ff === s) && k < 1000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 1000) bad_wait();
   endtask

   task automatic wait_run(input logic e);
      int k;
      k = 0;
      while (conv_active_ff !== e && k < 300) begin
         @(negedge clk);
         k++;
      end
      if (k >= 300) bad_wait();
   endtask

   task automatic next_cycle;
      wait_slot(3'h4);
      wait_slot(3'h0);
      repeat (3) @(negedge clk);
   endtask

   task automatic measure(input logic [2:0] s, output int cnt);
      int k;
      k = 0;
      while (adc_slot_ff === s && k < 1000) begin
         @(negedge clk);
         k++;
      end
      wait_slot(s);
      cnt = 0;
      while (adc_slot_ff === s && conv_active_ff === 1'b1 && cnt < 1000) begin
         @(negedge clk);
         cnt++;
      end
   endtask

   task automatic alert_is(input logic e);
      repeat (3) @(negedge clk);
      chk8({7'h00, alert_oe_n_ff}, {7'h00, e});
      chk8({7'h00, alert_out_ff}, 8'h00);
   endtask

   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   initial begin
      err_count = 0;
      cmp_count = 0;
      sys_rst = 1'b1;
      power_good = 1'b1;
      reg_req = '0;
      codes = {8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h19};
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk);
      rdc(ADDR_HOT, RST_HOT);
      rdc(ADDR_REL, RST_REL);
      for (i = 0; i < 8; i++) begin
         rdc(ADDR_VHI0 + 8'(i), i[0] ? RST_VLO : RST_VHI);
      end
      rdc(ADDR_CTRL_ALT, 8'h00);
      rdc(ADDR_STAT, 8'h00);
      rdc(ADDR_MASK, 8'h00);
      rdc(8'h50, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      measure(3'h0, n);
      chk_n(n, 40);
      measure(3'h1, n);
      chk_n(n, 20);
      wait_slot(3'h0);
      for (i = 1; i < 6; i++) begin
         v = {5'h00, adc_slot_ff};
         n = 0;
         while ({5'h00, adc_slot_ff} === v && n < 1000) begin
            @(negedge clk);
            n++;
         end
         chk8({5'h00, adc_slot_ff}, 8'(i % 5));
      end
      codes[2] = 8'hE0;
      next_cycle();
      alert_is(1'b0);
      rdc(ADDR_STAT, 8'h02);
      alert_is(1'b1);
      next_cycle();
      alert_is(1'b0);
      rdc(ADDR_STAT, 8'h02);
      wr(ADDR_MASK, 8'h02);
      next_cycle();
      rdc(ADDR_STAT, 8'h00);
      alert_is(1'b1);
      codes[2] = 8'hC0;
      wr(ADDR_MASK, 8'h00);
      for (i = 1; i < 5; i++) begin
         codes[i] = 8'h10;
         next_cycle();
         rdc(ADDR_STAT, 8'(8'h01 << (i - 1)));
         codes[i] = 8'hC0;
         next_cycle();
         rdc(ADDR_STAT, 8'h00);
      end
      wr(ADDR_CTRL, 8'h01);
      codes[1] = 8'h10;
      next_cycle();
      alert_is(1'b1);
      wr(ADDR_CTRL, 8'h03);
      alert_is(1'b0);
      wr(ADDR_CTRL, 8'h0B);
      alert_is(1'b1);
      repeat (250) @(negedge clk);
      chk8({7'h00, conv_active_ff}, 8'h00);
      rdc(ADDR_STAT, 8'h01);
      codes[1] = 8'hC0;
      wr(ADDR_CTRL, 8'h03);
      wait_slot(3'h2);
      codes[4] = 8'hC5;
      wr(ADDR_CTRL, 8'h02);
      wait_slot(3'h4);
      wait_run(1'b0);
      chk8({7'h00, conv_active_ff}, 8'h00);
      rdc(ADDR_VDATA0 + 8'h03, 8'hC5);
      wr(ADDR_CTRL, 8'h03);
      wait_run(1'b1);
      chk8({5'h00, adc_slot_ff}, 8'h00);
      wr(ADDR_TCFG, 8'h02);
      codes[0] = 8'h60;
      next_cycle();
      rdc(ADDR_STAT, 8'h10);
      rdc(ADDR_STAT, 8'h10);
      alert_is(1'b0);
      codes[0] = 8'h19;
      next_cycle();
      alert_is(1'b1);
      rdc(ADDR_STAT, 8'h00);
      wr(ADDR_TCFG, 8'h01);
      codes[0] = 8'h60;
      next_cycle();
      rdc(ADDR_STAT, 8'h10);
      next_cycle();
      rdc(ADDR_STAT, 8'h00);
      codes[0] = 8'h30;
      next_cycle();
      rdc(ADDR_STAT, 8'h10);
      wr(ADDR_HOT, 8'h70);
      wr(ADDR_CTRL, 8'h80);
      rdc(ADDR_HOT, RST_HOT);
      rdc(ADDR_CTRL_ALT, 8'h00);
      rdc(ADDR_TCFG, 8'h00);
      chk8({7'h00, conv_active_ff}, 8'h00);
      codes[0] = 8'h60;
      for (i = 0; i < 4; i += 3) begin
         wr(ADDR_TCFG, 8'(i));
         wr(ADDR_CTRL, 8'h03);
         next_cycle();
         rd(ADDR_STAT, v);
         next_cycle();
         rdc(ADDR_STAT, 8'h10);
      end
      codes[0] = 8'h19;
      wr(ADDR_CTRL, 8'h23);
      measure(3'h0, n);
      chk_n(n, 10);
      measure(3'h1, n);
      chk_n(n, 5);
      wr(ADDR_CTRL, 8'h13);
      measure(3'h0, n);
      chk_n((n >= 47 && n <= 48) ? 1 : 0, 1);
      wr(ADDR_HOT, 8'h70);
      power_good = 1'b0;
      repeat (8) @(negedge clk);
      power_good = 1'b1;
      repeat (8) @(negedge clk);
      rdc(ADDR_HOT, RST_HOT);
      chk8({7'h00, conv_active_ff}, 8'h00);
      wrap_up();
   end
endmodule
